/* File: rtl/tcap_pkg.sv */
// Shared constants and types of the terminal capability parser.
package tcap_pkg;

    // ------------------------------------------------------------
    // Command and TLV codes
    // ------------------------------------------------------------
    localparam logic [7:0] PARAM_ZERO   = 8'h00; // P1 and P2 value.
    localparam logic [7:0] TPL_TAG      = 8'ha9; // Template tag.
    localparam logic [7:0] TAG_POWER    = 8'h80; // Power supply.
    localparam logic [7:0] TAG_EXT_CHAN = 8'h81; // Extended channels.
    localparam logic [7:0] TAG_ADD_IF   = 8'h82; // Extra interfaces.
    localparam logic [7:0] TAG_PROFILE  = 8'h83; // Embedded profile.
    localparam logic [7:0] PRIV_MASK    = 8'hc0; // Bits b8 and b7.
    localparam logic [7:0] LEN_POWER    = 8'h03; // Power value size.
    localparam logic [7:0] LEN_ADD_IF   = 8'h01; // Interface size.
    localparam logic [7:0] FREQ_NONE    = 8'hff; // No clock given.
    localparam logic [7:0] CUR_MIN      = 8'h0a; // Least current.
    localparam logic [7:0] CUR_MAX      = 8'h3c; // Most current.
    localparam logic [7:0] VCLASS_MASK  = 8'hff; // Voltage bits kept.
    localparam logic [4:0] CHAN_BASE    = 5'h03; // Channels, default.
    localparam logic [4:0] CHAN_EXT     = 5'h13; // Channels, extended.

    // ------------------------------------------------------------
    // Register map, fields and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00; // Control.
    localparam logic [7:0]  ADDR_STATUS   = 8'h04; // Status.
    localparam logic [7:0]  ADDR_POWER    = 8'h08; // Power values.
    localparam logic [7:0]  ADDR_PROF_CAP = 8'h0c; // Profile bytes.
    localparam logic [7:0]  ADDR_PROF_LEN = 8'h10; // Profile length.
    localparam int          CTRL_EN_BIT   = 0;     // Parser enable.
    localparam logic        CTRL_RST      = 1'b1;  // Enabled at reset.

    // Command header handed over by the transport layer.
    typedef struct packed {
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] lc;
        logic       le_present;
    } cmd_hdr_t;

    // Capability values kept for the session.
    typedef struct packed {
        logic        pwr_seen;
        logic [7:0]  volt;
        logic [7:0]  cur;
        logic [7:0]  clk;
        logic        freq_ind;
        logic        ext_chan;
        logic        contactless_fe;
        logic        prof_seen;
        logic [7:0]  prof_len;
        logic [31:0] prof_cap;
    } caps_t;

    // Parser states, one-hot.
    typedef enum logic [6:0] {
        S_IDLE    = 7'h01,
        S_TPL_TAG = 7'h02,
        S_TPL_LEN = 7'h04,
        S_TAG     = 7'h08,
        S_LEN     = 7'h10,
        S_VAL     = 7'h20,
        S_DRAIN   = 7'h40
    } state_t;

endpackage

/* File: rtl/host_capability_tlv_parser.sv */
// Terminal capability command parser with its input byte FIFO.
//
// Functional notes
// R1 - P1, P2 zero, no Le; Lc counts data.
// R2 - Data opens with tag A9, one length.
// R3 - Private objects after defined ones are skipped.
// R4 - Terminal sends power object each session.
// R5 - Power object: length 3, voltage, current, clock.
// R6 - Clock byte in 0.1 MHz; FF means none.
// R7 - Voltage byte coded as reset-answer class.
// R8 - Terminal should report 10, 30, 60 mA.
// R9 - Terminal sends extended-channel object each session.
// R10 - Extended-channel object read as zero length.
// R11 - Terminal sends extra-interface object each session.
// R12 - Extra-interface bit b1 marks contactless support.
// R13 - Extra-interface bytes past first are ignored.
// R14 - Profile object bytes accepted and kept; here only the first four bytes and the length are kept.
// R15 - Without extension, only three extra channels.
// R16 - Terminal sends command only if advertised.
// R17 - Values held per session, committed when complete.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------
module tcap_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    // Pointers wrap by overflow, so only powers of two are served.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("FIFO depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];   // Storage words.
    logic [AW-1:0]    wr_ptr_reg;    // Next write slot.
    logic [AW-1:0]    rd_ptr_reg;    // Oldest word.
    logic [CW-1:0]    count_reg;     // Words held.
    logic [CW-1:0]    count_next;
    wire              push = i_in_valid && o_in_ready;
    wire              pull = i_out_ready && o_out_valid;

    assign o_out_valid = (count_reg != '0);
    assign o_out_data  = mem[rd_ptr_reg];
    assign count_next  = count_reg + CW'(push) - CW'(pull);

    // Ready is registered so the source sees a clean flop.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            o_in_ready <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pull);
            count_reg  <= count_next;
            o_in_ready <= (count_next < CW'(DEPTH));
        end
    end

    // Storage has no reset; empty words are never read out.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end
endmodule

// ----------------------------------------------------------------
// Parser top
// ----------------------------------------------------------------
module host_capability_tlv_parser #(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_cmd_valid,
    input  wire tcap_pkg::cmd_hdr_t i_cmd_hdr,
    input  wire logic               i_byte_valid,
    input  wire logic [7:0]         i_byte_data,
    output logic                    o_byte_ready,
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic [31:0]             o_rdata,
    output logic                    o_cmd_done,
    output logic                    o_cmd_ok,
    output logic                    o_busy,
    output tcap_pkg::caps_t         o_caps,
    output logic [4:0]              o_max_chan
);
    tcap_pkg::state_t   st_reg;      // Parser state.
    tcap_pkg::state_t   st_walk;     // State before end-of-data.
    tcap_pkg::state_t   st_next;
    tcap_pkg::cmd_hdr_t hdr_reg;     // Header of current command.
    tcap_pkg::caps_t    sh_reg;      // Shadow values of the parse.
    logic [7:0]         lc_left_reg; // Data bytes still due.
    logic [7:0]         tpl_left_reg;// Template bytes still due.
    logic [7:0]         obj_left_reg;// Value bytes still due.
    logic [7:0]         idx_reg;     // Value byte index.
    logic [7:0]         tag_reg;     // Tag of current object.
    logic               err_reg;     // Command already failed.
    logic               err_set;
    logic               en_reg;      // Parser enable.
    logic               f_valid;
    logic [7:0]         b;           // Byte at FIFO head.
    // A byte leaves the FIFO whenever a command is being walked.
    wire                pop = f_valid && (st_reg != tcap_pkg::S_IDLE);

    tcap_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (i_byte_valid),
        .i_in_data   (i_byte_data),
        .o_in_ready  (o_byte_ready),
        .o_out_valid (f_valid),
        .o_out_data  (b),
        .i_out_ready (pop)
    );

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire start    = i_cmd_valid && (st_reg == tcap_pkg::S_IDLE);
    wire last     = (lc_left_reg == 8'h01);
    wire tpl_end  = (tpl_left_reg == 8'h01);
    wire tpl_fit  = (b <= lc_left_reg - 8'h01);
    wire obj_fit  = (b <= tpl_left_reg - 8'h01);
    wire len_pop  = pop && (st_reg == tcap_pkg::S_LEN);
    wire val_pop  = pop && (st_reg == tcap_pkg::S_VAL);
    wire is_pwr   = (tag_reg == tcap_pkg::TAG_POWER);
    wire is_if    = (tag_reg == tcap_pkg::TAG_ADD_IF);
    wire is_prof  = (tag_reg == tcap_pkg::TAG_PROFILE);
    wire is_ext   = (tag_reg == tcap_pkg::TAG_EXT_CHAN);
    // Private and unknown tags fall through every store below.
    wire is_priv  = ((tag_reg & tcap_pkg::PRIV_MASK)
                     == tcap_pkg::PRIV_MASK);                // [R3]
    // Header must carry zero P1, P2 and no Le field.
    wire hdr_bad  = (i_cmd_hdr.p1 != tcap_pkg::PARAM_ZERO)
                 || (i_cmd_hdr.p2 != tcap_pkg::PARAM_ZERO)
                 || i_cmd_hdr.le_present || !en_reg;       // [R1]
    // Short power or interface objects fail the command.
    wire len_bad  = (is_pwr && b < tcap_pkg::LEN_POWER)
                 || (is_if && b < tcap_pkg::LEN_ADD_IF);  // [R5] [R12]
    wire fin      = pop && last;
    wire fin_ok   = fin && !err_reg && !err_set
                 && (st_walk == tcap_pkg::S_DRAIN);        // [R17]
    wire cur_ok   = (o_caps.cur >= tcap_pkg::CUR_MIN)
                 && (o_caps.cur <= tcap_pkg::CUR_MAX);     // [R8]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Errors do not stop the walk: the rest of Lc is drained so
    // the transport and the parser stay aligned.
    always_comb begin
        st_walk = st_reg;
        err_set = 1'b0;
        unique case (st_reg)
            tcap_pkg::S_IDLE: begin
                if (start && i_cmd_hdr.lc != 8'h00) begin
                    st_walk = tcap_pkg::S_TPL_TAG;
                end
            end
            tcap_pkg::S_TPL_TAG: begin
                if (pop) begin
                    err_set = (b != tcap_pkg::TPL_TAG);      // [R2]
                    st_walk = err_set ? tcap_pkg::S_DRAIN
                                      : tcap_pkg::S_TPL_LEN;
                end
            end
            tcap_pkg::S_TPL_LEN: begin
                if (pop) begin
                    err_set = !tpl_fit;                      // [R2]
                    st_walk = (err_set || b == 8'h00)
                            ? tcap_pkg::S_DRAIN : tcap_pkg::S_TAG;
                end
            end
            tcap_pkg::S_TAG: begin
                if (pop) begin
                    err_set = tpl_end;
                    st_walk = tpl_end ? tcap_pkg::S_DRAIN
                                      : tcap_pkg::S_LEN;
                end
            end
            tcap_pkg::S_LEN: begin
                if (pop) begin
                    err_set = !obj_fit || len_bad;
                    if (err_set || (b == 8'h00 && tpl_end)) begin
                        st_walk = tcap_pkg::S_DRAIN;
                    end else if (b == 8'h00) begin
                        st_walk = tcap_pkg::S_TAG;
                    end else begin
                        st_walk = tcap_pkg::S_VAL;
                    end
                end
            end
            tcap_pkg::S_VAL: begin
                if (pop && obj_left_reg == 8'h01) begin
                    st_walk = tpl_end ? tcap_pkg::S_DRAIN
                                      : tcap_pkg::S_TAG;
                end
            end
            tcap_pkg::S_DRAIN: begin
                st_walk = tcap_pkg::S_DRAIN;
            end
        endcase
        st_next = fin ? tcap_pkg::S_IDLE : st_walk;
    end

    // ------------------------------------------------------------
    // Walk counters
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_reg       <= tcap_pkg::S_IDLE;
            hdr_reg      <= '0;
            err_reg      <= 1'b0;
            lc_left_reg  <= 8'h00;
            tpl_left_reg <= 8'h00;
            obj_left_reg <= 8'h00;
            idx_reg      <= 8'h00;
            tag_reg      <= 8'h00;
        end else begin
            st_reg <= st_next;
            if (start) begin
                hdr_reg     <= i_cmd_hdr;
                err_reg     <= hdr_bad;                      // [R1]
                lc_left_reg <= i_cmd_hdr.lc;                 // [R1]
            end else begin
                err_reg     <= err_reg || err_set;
                lc_left_reg <= lc_left_reg - 8'(pop);
            end
            if (pop && st_reg == tcap_pkg::S_TPL_LEN) begin
                tpl_left_reg <= b;                           // [R2]
            end else if (pop && st_reg != tcap_pkg::S_DRAIN
                         && st_reg != tcap_pkg::S_TPL_TAG) begin
                tpl_left_reg <= tpl_left_reg - 8'h01;
            end
            if (pop && st_reg == tcap_pkg::S_TAG) begin
                tag_reg <= b;
            end
            if (len_pop) begin
                obj_left_reg <= b;
                idx_reg      <= 8'h00;
            end else if (val_pop) begin
                obj_left_reg <= obj_left_reg - 8'h01;
                idx_reg      <= idx_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Shadow values
    // ------------------------------------------------------------
    // The shadow starts from the held values, so objects absent
    // from this command leave the earlier ones standing.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sh_reg <= '0;
        end else if (start) begin
            sh_reg <= o_caps;
        end else begin
            if (len_pop && obj_fit && is_ext) begin
                sh_reg.ext_chan <= 1'b1;                     // [R10]
            end
            if (len_pop && obj_fit && is_prof) begin
                sh_reg.prof_seen <= 1'b1;                    // [R14]
                sh_reg.prof_len  <= b;                       // [R14]
            end
            if (val_pop && is_pwr && idx_reg == 8'h00) begin
                sh_reg.volt <= b & tcap_pkg::VCLASS_MASK;    // [R7]
            end
            if (val_pop && is_pwr && idx_reg == 8'h01) begin
                sh_reg.cur <= b;                             // [R5]
            end
            if (val_pop && is_pwr && idx_reg == 8'h02) begin
                sh_reg.clk      <= b;                        // [R5]
                sh_reg.pwr_seen <= 1'b1;
            end
            // Only b1 counts; later bytes are left for extensions.
            if (val_pop && is_if && idx_reg == 8'h00) begin
                sh_reg.contactless_fe <= b[0];          // [R12] [R13]
            end
            // Bytes past the fourth are accepted but not kept.
            if (val_pop && is_prof && idx_reg < 8'h04) begin
                sh_reg.prof_cap[{idx_reg[1:0], 3'b000} +: 8] <= b;
            end
        end
    end

    // ------------------------------------------------------------
    // Session values and command result
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_caps     <= '0;                                // [R17]
            o_max_chan <= tcap_pkg::CHAN_BASE;               // [R15]
            o_cmd_done <= 1'b0;
            o_cmd_ok   <= 1'b0;
            o_busy     <= 1'b0;
        end else begin
            if (fin_ok) begin
                o_caps          <= sh_reg;                   // [R17]
                o_caps.freq_ind <= sh_reg.pwr_seen
                    && sh_reg.clk != tcap_pkg::FREQ_NONE;    // [R6]
                o_max_chan <= sh_reg.ext_chan ? tcap_pkg::CHAN_EXT
                                : tcap_pkg::CHAN_BASE;       // [R15]
            end
            o_cmd_done <= fin || (start && i_cmd_hdr.lc == 8'h00);
            o_cmd_ok   <= fin_ok;
            o_busy     <= (st_next != tcap_pkg::S_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    wire [31:0] rd_status = {25'h0, err_reg, cur_ok, o_caps.prof_seen,
                             o_caps.contactless_fe, o_caps.ext_chan,
                             o_busy, o_caps.pwr_seen};
    wire [31:0] rd_power  = {7'h0, o_caps.freq_ind, o_caps.clk,
                             o_caps.cur, o_caps.volt};
    wire [31:0] rd_mux    =
        (i_addr == tcap_pkg::ADDR_CTRL)     ? {31'h0, en_reg} :
        (i_addr == tcap_pkg::ADDR_STATUS)   ? rd_status :
        (i_addr == tcap_pkg::ADDR_POWER)    ? rd_power :
        (i_addr == tcap_pkg::ADDR_PROF_CAP) ? o_caps.prof_cap :
        (i_addr == tcap_pkg::ADDR_PROF_LEN) ? {24'h0, o_caps.prof_len}
                                            : 32'h0;

    // Read data stand for one cycle only; unmapped reads give zero.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            en_reg  <= tcap_pkg::CTRL_RST;
            o_rdata <= 32'h0;
        end else begin
            if (i_wr && i_addr == tcap_pkg::ADDR_CTRL) begin
                en_reg <= i_wdata[tcap_pkg::CTRL_EN_BIT];
            end
            o_rdata <= i_rd ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    hdr_check_a: assert property (o_cmd_ok |-> hdr_reg.p1 == 8'h00 // [R1]
        && hdr_reg.p2 == 8'h00 && !hdr_reg.le_present)
        else $error("command accepted with bad header");
    tpl_tag_a: assert property (pop && st_reg == tcap_pkg::S_TPL_TAG // [R2]
        && b != 8'ha9 |=> err_reg ##1 !o_cmd_ok)
        else $error("wrong template tag not refused");
    priv_skip_a: assert property (val_pop && is_priv // [R3]
        |=> $stable(sh_reg))
        else $error("private object changed values");
    pwr_len_a: assert property (len_pop && is_pwr && b < 8'h03 // [R5]
        |=> err_reg)
        else $error("short power object not refused");
    freq_ind_a: assert property (o_caps.freq_ind // [R6]
        |-> o_caps.clk != 8'hff && o_caps.pwr_seen)
        else $error("frequency flagged for none value");
    ext_len_a: assert property (len_pop && is_ext && obj_fit // [R10]
        |=> sh_reg.ext_chan)
        else $error("extended channel object not taken");
    if_bit_a: assert property (val_pop && is_if && idx_reg == 8'h00 // [R12]
        |=> sh_reg.contactless_fe == $past(b[0]))
        else $error("interface bit not taken");
    if_extra_a: assert property (val_pop && is_if && idx_reg != 8'h00 // [R13]
        |=> $stable(sh_reg.contactless_fe))
        else $error("extra interface byte used");
    chan_cap_a: assert property (!o_caps.ext_chan // [R15]
        |-> o_max_chan == 5'h03)
        else $error("channel limit exceeded");
    commit_a: assert property (!$stable(o_caps) // [R17]
        && $past(i_rst_b) |-> o_cmd_done && o_cmd_ok)
        else $error("values changed without complete command");

    ok_cmd_c: cover property (o_cmd_ok && o_caps.pwr_seen);
    bad_cmd_c: cover property (o_cmd_done && !o_cmd_ok);
    full_c: cover property (!o_byte_ready);
endmodule

/* File: sim/tcap_terminal_model.sv */
// Terminal model that sends capability headers and data bytes.
`timescale 1ns/1ps
module tcap_terminal_model (
    input  wire logic          i_clk,
    input  wire logic          i_byte_ready,
    output tcap_pkg::cmd_hdr_t o_cmd_hdr,
    output logic               o_cmd_valid,
    output logic               o_byte_valid,
    output logic [7:0]         o_byte_data
);
    // Idle lines. Data shows 5A at start, then the inverse of the last byte when not offered.
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_hdr = '0;
        o_byte_valid = 1'b0;
        o_byte_data = 8'h5a;
    end
    // One header pulse, sent on every call; what the card offers is not checked.
    task automatic send_hdr(input tcap_pkg::cmd_hdr_t h);
        @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_hdr <= h;
        @(posedge i_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_hdr <= ~h;
    endtask
    // Offer a byte after a stall; hold it until the card takes it.
    task automatic push(input logic [7:0] b, input int stall);
        @(posedge i_clk);
        repeat (stall) @(posedge i_clk);
        o_byte_valid <= 1'b1;
        o_byte_data <= b;
        @(posedge i_clk);
        while (i_byte_ready !== 1'b1) @(posedge i_clk);
        o_byte_valid <= 1'b0;
        o_byte_data <= ~b;
    endtask
endmodule

/* File: sim/host_capability_tlv_parser_test.sv */
// Self-checking bench of the terminal capability parser.
`timescale 1ns/1ps
module host_capability_tlv_parser_test;
    logic               i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0;
    logic               i_rd = 1'b0, o_byte_ready, o_cmd_done, o_cmd_ok;
    logic               o_busy, cmd_valid, byte_valid, err_e;
    logic [7:0]         i_addr = 8'h00, byte_data, v, c, k, ifb;
    logic [31:0]        i_wdata = 32'h0, o_rdata;
    logic [4:0]         o_max_chan;
    logic [7:0]         q[$];
    tcap_pkg::cmd_hdr_t hdr, h;
    tcap_pkg::caps_t    o_caps, exp_c;
    int                 seed = 32'h535925ed, mismatches = 0;
    int                 n_checks = 0, cycles = 0;

    always #10 i_clk = ~i_clk;

    host_capability_tlv_parser #(.FIFO_DEPTH(32)) i_dut (.i_clk(i_clk),
        .i_rst_b(i_rst_b), .i_cmd_valid(cmd_valid), .i_cmd_hdr(hdr),
        .i_byte_valid(byte_valid), .i_byte_data(byte_data),
        .o_byte_ready(o_byte_ready), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_cmd_done(o_cmd_done), .o_cmd_ok(o_cmd_ok), .o_busy(o_busy),
        .o_caps(o_caps), .o_max_chan(o_max_chan));
    tcap_terminal_model i_term (.i_clk(i_clk),
        .i_byte_ready(o_byte_ready), .o_cmd_hdr(hdr),
        .o_cmd_valid(cmd_valid), .o_byte_valid(byte_valid),
        .o_byte_data(byte_data));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [95:0] s, e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 check("rdata", 96'(o_rdata), 96'(e));
    endtask
    // Status and power words the registers should show.
    function automatic logic [31:0] st();
        return {25'h0, err_e, exp_c.cur >= tcap_pkg::CUR_MIN &&
            exp_c.cur <= tcap_pkg::CUR_MAX, exp_c.prof_seen,
            exp_c.contactless_fe, exp_c.ext_chan, 1'b0, exp_c.pwr_seen};
    endfunction
    function automatic logic [31:0] pw();
        return {7'h0, exp_c.freq_ind, exp_c.clk, exp_c.cur, exp_c.volt};
    endfunction
    // One command; pre fills the FIFO before the header is sent.
    task automatic run(input bit pre, input logic ok_e);
        int n;
        if (pre) foreach (q[i]) i_term.push(q[i], $random(seed) & 3);
        if (pre) #1 check("ready_full", 96'(o_byte_ready), 96'(0));
        i_term.send_hdr(h);
        #1 check("busy", 96'(o_busy), 96'(h.lc != 8'h00));
        if (!pre) foreach (q[i]) i_term.push(q[i], $random(seed) & 3);
        n = 0;
        while (o_cmd_done !== 1'b1 && n < 400) begin
            @(posedge i_clk);
            #1 n++;
        end
        check("done", 96'(o_cmd_done), 96'(1));
        check("ok", 96'(o_cmd_ok), 96'(ok_e));
        check("idle", 96'(o_busy), 96'(0));
        check("caps", 96'(o_caps), 96'(exp_c));
        rd(tcap_pkg::ADDR_STATUS, st());
        rd(tcap_pkg::ADDR_POWER, pw());
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (cycles > 30000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        exp_c = '0;
        err_e = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(tcap_pkg::ADDR_CTRL, 32'h1);
        rd(8'h20, 32'h0);
        rd(tcap_pkg::ADDR_STATUS, st());
        check("chan", 96'(o_max_chan), 96'(3));
        $display("test reset finished");
        // Power, extra interface, channel and private objects.
        for (int t = 0; t < 6; t++) begin
            v = $random(seed);
            k = (t == 0) ? 8'hff : 8'($random(seed));
            c = (t == 1) ? 8'h3d : 8'h0a + 8'($random(seed) & 8'h1f);
            ifb = $random(seed);
            q = {8'ha9, (t == 3) ? 8'h0f : 8'h0c, 8'h80, 8'h03, v, c, k,
                 8'h82, 8'h02, ifb, 8'hee};
            if (t == 3) q = {q, 8'h81, 8'h01, 8'h55};
            q = {q, 8'hc1, 8'h01, 8'($random(seed))};
            h = '{8'h00, 8'h00, 8'(q.size()), 1'b0};
            exp_c.pwr_seen = 1'b1;
            exp_c.volt = v;
            exp_c.cur = c;
            exp_c.clk = k;
            exp_c.freq_ind = (k != 8'hff);
            exp_c.contactless_fe = ifb[0];
            exp_c.ext_chan |= (t == 3);
            run(1'b0, 1'b1);
            check("chan", 96'(o_max_chan), 96'(exp_c.ext_chan ? 19 : 3));
        end
        $display("test objects finished");
        // Refused headers, bad template, short power, disabled parser.
        for (int e = 0; e < 7; e++) begin
            q = {8'ha9, 8'h05, 8'h80, 8'h03, 8'h11, 8'h22, 8'h33};
            h = '{8'(e == 0), 8'(e == 1), 8'h07, e == 2};
            if (e == 3) q[0] = 8'ha8;
            if (e == 4) q[3] = 8'h02;
            if (e == 5) q[1] = 8'h06;
            if (e == 6) wr(tcap_pkg::ADDR_CTRL, 32'h0);
            err_e = 1'b1;
            run(1'b0, 1'b0);
        end
        wr(tcap_pkg::ADDR_CTRL, 32'h1);
        $display("test refusals finished");
        // Full FIFO holds a 32-byte command with a profile object.
        q = {8'ha9, 8'h1e, 8'h83, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04,
             8'h05, 8'h80, 8'h03, 8'h01, 8'h3c, 8'h0a, 8'hc1, 8'h10};
        repeat (16) q.push_back(8'($random(seed)));
        h = '{8'h00, 8'h00, 8'h20, 1'b0};
        exp_c.prof_seen = 1'b1;
        exp_c.prof_len = 8'h05;
        exp_c.prof_cap = 32'h04030201;
        {exp_c.volt, exp_c.cur, exp_c.clk} = 24'h013c0a;
        exp_c.freq_ind = 1'b1;
        err_e = 1'b0;
        run(1'b1, 1'b1);
        rd(tcap_pkg::ADDR_PROF_CAP, 32'h04030201);
        rd(tcap_pkg::ADDR_PROF_LEN, 32'h5);
        $display("test profile finished");
        // A session reset between commands, with the parser idle, clears every held value.
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1 check("caps_rst", 96'(o_caps), 96'(0));
        check("chan_rst", 96'(o_max_chan), 96'(3));
        rd(tcap_pkg::ADDR_STATUS, 32'h0);
        $display("test session finished");
        report_and_stop();
    end
endmodule
